// [hw/hpsc_cfg.svh]
`ifndef HPSC_CFG_SVH
`define HPSC_CFG_SVH
//==========================================================
// Overview of operation
// - Each status shift clock rise with strobe high moves the status chain one bit.
// - Strobe low at a status clock rise loads slot status in parallel.
// - Status chain takes new bits from the downstream device input.
// - Last status chain bit drives the status chain output.
// - Status output floats while power invalid; sampled as strap bit 0 on rise.
// - Each control shift clock rise moves control chain one bit from input.
// - Bits leaving the control chain drive the control chain output.
// - Control output floats while power invalid; sampled as strap bit 1 on rise.
// - Control latch clock rise copies chain into all non-reset outputs.
// - Reset latch clock rise updates only the slot bus reset latches.
// - Control latch clear zeroes all non-reset output latches.
// - Reset latch clear zeroes only the slot bus reset latches.
// - Each slot has its own bus reset output from its latch.
// - Switch input low means slot closed; level reported in status.
// - Switch at 5 V forces main power on and auxiliary power off.
// - Test high at power valid rise selects strap test mode.
// - Test raised later maps power enable and fault to indicators.
// - Open switch removes slot auxiliary supply; closing restores it.
// - Aux undervoltage and per-slot aux overcurrent raise fault flags.
// - Power valid acts as reset; serial interface idle while low.
// - Latched control drives power, bus, clock, reset and indicators.
// - Status holds switch, button, presence, speed, mode and fault bits.
//==========================================================
`define HPSC_SYNC_STAGES 2
`define HPSC_STAT_W 18
`define HPSC_CTRL_W 12
`define HPSC_STAT_PER_SLOT 9
`define HPSC_CTRL_PER_SLOT 6
// Control field positions within one slot
`define HPSC_C_PWREN 0
`define HPSC_C_BUSEN 1
`define HPSC_C_CLKEN 2
`define HPSC_C_RESET 3
`define HPSC_C_ATTN 4
`define HPSC_C_PWRIND 5
// Register byte offsets
`define HPSC_REG_CTRL 8'h00
`define HPSC_REG_STAT 8'h04
`define HPSC_REG_OUTS 8'h08
`define HPSC_REG_CAPT 8'h0C
`define HPSC_CTRL_RST 32'h0000_0001
`define HPSC_CTRL_EN_BIT 0
`define HPSC_CTRL_FREEZE_BIT 1
`endif

// [hw/hpsc_pkg.sv]
`default_nettype none
package hpsc_pkg;
   typedef enum logic [1:0] {
      OP_OFF,
      OP_NORMAL,
      OP_TEST
   } hpsc_op_t;
   typedef logic [1:0] hpsc_strap_t;
endpackage
`default_nettype wire

// [hw/hpsc_sync.sv]
`default_nettype none
module hpsc_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   // First stage feeds only the second stage
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= d_i;
         sync_r <= meta_r;
      end
   end
   assign q_o = sync_r;
endmodule
`default_nettype wire

// [hw/hpsc_ahb.sv]
`default_nettype none
`include "hpsc_cfg.svh"
module hpsc_ahb (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic [31:0] stat_word_i,
   input wire logic [31:0] outs_word_i,
   input wire logic [31:0] capt_word_i,
   output logic [31:0] ctrl_o
);
   logic [31:0] ctrl_r;
   logic [31:0] rdata_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   // Word transfers only; hsize is accepted but not checked
   wire take = hsel_i && hready_i && htrans_i[1];
   wire [7:0] a = haddr_i[7:0];
   wire [31:0] rd_mux = (a == `HPSC_REG_CTRL) ? ctrl_r :
                        (a == `HPSC_REG_STAT) ? stat_word_i :
                        (a == `HPSC_REG_OUTS) ? outs_word_i :
                        (a == `HPSC_REG_CAPT) ? capt_word_i : 32'h0000_0000;
   wire unused_ok = &{1'b0, haddr_i[31:8], hsize_i};
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_r <= `HPSC_CTRL_RST;
         rdata_r <= 32'h0000_0000;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= take && hwrite_i;
         if (take) wr_addr_r <= a;
         if (take && !hwrite_i) rdata_r <= rd_mux;
         if (wr_pend_r && wr_addr_r == `HPSC_REG_CTRL) ctrl_r <= hwdata_i;
      end
   end
   assign hrdata_o = rdata_r;
   assign hreadyout_o = 1'b1;
   assign hresp_o = unused_ok;
   assign ctrl_o = ctrl_r;
endmodule
`default_nettype wire

// [hw/hpsc_top.sv]
`default_nettype none
`include "hpsc_cfg.svh"
module hpsc_top (
   input wire logic clk_i,
   input wire logic nrst_i,
   // Serial link pins
   input wire logic status_shift_clock_i,
   input wire logic status_chain_in_i,
   input wire logic status_capture_strobe_n_i,
   input wire logic status_chain_out_i,
   output logic status_chain_out_o,
   output logic status_chain_out_oe_o,
   input wire logic control_shift_clock_i,
   input wire logic control_chain_in_i,
   input wire logic control_chain_out_i,
   output logic control_chain_out_o,
   output logic control_chain_out_oe_o,
   input wire logic control_latch_clock_i,
   input wire logic slot_reset_latch_clock_i,
   input wire logic control_latch_clear_i,
   input wire logic slot_reset_latch_clear_i,
   input wire logic power_valid_in_i,
   input wire logic test_i,
   // Slot pins, index 0 is slot A
   input wire logic [1:0] slot_switch_n_i,
   input wire logic [1:0] slot_switch_5v_i,
   input wire logic [1:0] attention_button_i,
   input wire logic [1:0] presence_bit1_i,
   input wire logic [1:0] presence_bit2_i,
   input wire logic [1:0] speed66_capable_i,
   input wire logic [1:0] extended_mode_cap1_i,
   input wire logic [1:0] extended_mode_cap2_i,
   input wire logic [1:0] main_power_fault_i,
   input wire logic [1:0] aux_overcurrent_i,
   input wire logic aux_undervoltage_i,
   output logic [1:0] main_power_enable_o,
   output logic [1:0] aux_power_enable_o,
   output logic [1:0] bus_connect_enable_o,
   output logic [1:0] clock_connect_enable_o,
   output logic [1:0] slot_bus_reset_o,
   output logic [1:0] attention_indicator_o,
   output logic [1:0] power_indicator_o,
   output logic test_mode_o,
   output logic [1:0] strap_select_o,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o
);
   localparam int SW = `HPSC_STAT_W;
   localparam int CW = `HPSC_CTRL_W;
   localparam int NP = 34;

   //==========================================================
   // Pin synchronisation
   //==========================================================
   logic [NP-1:0] pin_raw;
   logic [NP-1:0] pin_s;
   assign pin_raw = {status_shift_clock_i, status_chain_in_i, status_capture_strobe_n_i,
                     status_chain_out_i, control_shift_clock_i, control_chain_in_i,
                     control_chain_out_i, control_latch_clock_i, slot_reset_latch_clock_i,
                     control_latch_clear_i, slot_reset_latch_clear_i, power_valid_in_i,
                     test_i, slot_switch_n_i, slot_switch_5v_i, attention_button_i,
                     presence_bit1_i, presence_bit2_i, speed66_capable_i,
                     extended_mode_cap1_i, extended_mode_cap2_i, main_power_fault_i,
                     aux_overcurrent_i, aux_undervoltage_i};

   hpsc_sync #(.W(NP)) u_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .d_i(pin_raw),
      .q_o(pin_s)
   );

   wire s_clk = pin_s[33];
   wire s_din = pin_s[32];
   wire s_ld_n = pin_s[31];
   wire s_pin = pin_s[30];
   wire c_clk = pin_s[29];
   wire c_din = pin_s[28];
   wire c_pin = pin_s[27];
   wire l_clk = pin_s[26];
   wire r_clk = pin_s[25];
   wire l_clr = pin_s[24];
   wire r_clr = pin_s[23];
   wire pv = pin_s[22];
   wire tst = pin_s[21];
   wire [1:0] sw_n = pin_s[20:19];
   wire [1:0] sw_5v = pin_s[18:17];
   wire [1:0] btn = pin_s[16:15];
   wire [1:0] prs1 = pin_s[14:13];
   wire [1:0] prs2 = pin_s[12:11];
   wire [1:0] m66 = pin_s[10:9];
   wire [1:0] xc1 = pin_s[8:7];
   wire [1:0] xc2 = pin_s[6:5];
   wire [1:0] pflt = pin_s[4:3];
   wire [1:0] aoc = pin_s[2:1];
   wire auv = pin_s[0];

   //==========================================================
   // Edge detection on the link clocks
   //==========================================================
   logic [3:0] edge_q_r;
   logic pv_q_r;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         edge_q_r <= 4'h0;
         pv_q_r <= 1'b0;
      end else begin
         edge_q_r <= {s_clk, c_clk, l_clk, r_clk};
         pv_q_r <= pv;
      end
   end
   wire s_rise = s_clk && !edge_q_r[3];
   wire c_rise = c_clk && !edge_q_r[2];
   wire l_rise = l_clk && !edge_q_r[1];
   wire r_rise = r_clk && !edge_q_r[0];
   wire pv_rise = pv && !pv_q_r;

   //==========================================================
   // Software control and operating mode
   //==========================================================
   logic [31:0] ctrl_w;
   hpsc_pkg::hpsc_op_t op_r;
   hpsc_pkg::hpsc_op_t op_nxt;
   hpsc_pkg::hpsc_strap_t strap_r;

   // Software can hold the serial interface off, or stop the two latch clocks loading the output latches
   wire sw_en = ctrl_w[`HPSC_CTRL_EN_BIT];
   wire sw_freeze = ctrl_w[`HPSC_CTRL_FREEZE_BIT];
   wire normal = (op_r == hpsc_pkg::OP_NORMAL);
   wire link_on = normal && sw_en;
   wire late_test = normal && tst;

   always_comb begin
      op_nxt = op_r;
      unique case (op_r)
         hpsc_pkg::OP_OFF: begin
            if (pv_rise) op_nxt = tst ? hpsc_pkg::OP_TEST : hpsc_pkg::OP_NORMAL;
         end
         hpsc_pkg::OP_NORMAL: begin
            if (!pv) op_nxt = hpsc_pkg::OP_OFF;
         end
         hpsc_pkg::OP_TEST: begin
            if (!pv) op_nxt = hpsc_pkg::OP_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         op_r <= hpsc_pkg::OP_OFF;
         strap_r <= 2'b00;
      end else begin
         op_r <= op_nxt;
         if (pv_rise) strap_r <= {c_pin, s_pin};
      end
   end

   //==========================================================
   // Fault tracking
   //==========================================================
   logic [1:0] aux_flt_r;
   wire [1:0] sw_closed = ~sw_n;
   wire [1:0] fault = pflt | aux_flt_r;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         aux_flt_r <= 2'b00;
      end else begin
         // Latched until the switch opens; set wins over that clear
         aux_flt_r <= (aux_flt_r & sw_closed) | aoc | {2{auv}};
      end
   end

   //==========================================================
   // Status capture chain
   //==========================================================
   logic [SW-1:0] s_chain_r;
   logic [SW-1:0] stat_vec;

   // Pins passed as arguments so the assignment follows every change
   wire [13:0] st_pins = {xc2, xc1, m66, prs2, prs1, btn, sw_n};

   function automatic logic [8:0] slot_status(input int s, input logic [1:0] fl,
                                             input logic [1:0] af, input logic [13:0] p);
      slot_status = {~fl[s], ~af[s], p[12+s], p[10+s], p[8+s], p[6+s], p[4+s], p[2+s], p[s]};
   endfunction

   assign stat_vec = {slot_status(1, fault, aux_flt_r, st_pins),
                      slot_status(0, fault, aux_flt_r, st_pins)};

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_chain_r <= '0;
      end else if (!link_on) begin
         s_chain_r <= '0;
      end else if (s_rise) begin
         if (!s_ld_n) s_chain_r <= stat_vec;
         else s_chain_r <= {s_chain_r[SW-2:0], s_din};
      end
   end

   assign status_chain_out_o = s_chain_r[SW-1];
   assign status_chain_out_oe_o = normal;

   //==========================================================
   // Control shift chain
   //==========================================================
   logic [CW-1:0] c_chain_r;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         c_chain_r <= '0;
      end else if (!link_on) begin
         c_chain_r <= '0;
      end else if (c_rise) begin
         c_chain_r <= {c_chain_r[CW-2:0], c_din};
      end
   end

   assign control_chain_out_o = c_chain_r[CW-1];
   assign control_chain_out_oe_o = normal;

   //==========================================================
   // Parallel output latches
   //==========================================================
   logic [CW-1:0] lat_r;
   logic [CW-1:0] rst_mask;

   function automatic logic [CW-1:0] reset_field_mask();
      logic [CW-1:0] m;
      m = '0;
      for (int s = 0; s < 2; s++) m[s*`HPSC_CTRL_PER_SLOT + `HPSC_C_RESET] = 1'b1;
      return m;
   endfunction

   assign rst_mask = reset_field_mask();
   wire l_take = link_on && !sw_freeze && l_rise;
   wire r_take = link_on && !sw_freeze && r_rise;
   wire [CW-1:0] lat_gen = l_clr ? '0 : (l_take ? c_chain_r : lat_r);
   wire [CW-1:0] lat_rst = r_clr ? '0 : (r_take ? c_chain_r : lat_r);
   wire [CW-1:0] lat_nxt = (lat_gen & ~rst_mask) | (lat_rst & rst_mask);

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lat_r <= '0;
      end else if (!pv) begin
         lat_r <= '0;
      end else begin
         lat_r <= lat_nxt;
      end
   end

   function automatic logic [1:0] field(input logic [CW-1:0] l, input int f);
      field = {l[`HPSC_CTRL_PER_SLOT + f], l[f]};
   endfunction

   //==========================================================
   // Slot outputs
   //==========================================================
   wire [1:0] pwren = field(lat_r, `HPSC_C_PWREN) | sw_5v;
   assign main_power_enable_o = pwren;
   assign aux_power_enable_o = sw_closed & ~sw_5v & ~aux_flt_r;
   assign bus_connect_enable_o = field(lat_r, `HPSC_C_BUSEN);
   assign clock_connect_enable_o = field(lat_r, `HPSC_C_CLKEN);
   assign slot_bus_reset_o = field(lat_r, `HPSC_C_RESET);
   // With power invalid the attention lamp still shows the aux fault
   assign attention_indicator_o = !pv ? aux_flt_r :
                                  late_test ? fault : field(lat_r, `HPSC_C_ATTN);
   assign power_indicator_o = late_test ? pwren : field(lat_r, `HPSC_C_PWRIND);
   assign test_mode_o = (op_r == hpsc_pkg::OP_TEST);
   assign strap_select_o = strap_r;

   //==========================================================
   // Register bus
   //==========================================================
   wire [31:0] stat_word = {24'h0000_00, aux_flt_r, strap_r, tst, test_mode_o, normal, pv};
   wire [31:0] outs_word = {20'h0_0000, lat_r};
   wire [31:0] capt_word = {14'h0000, stat_vec};

   hpsc_ahb u_ahb (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .hsel_i(hsel_i),
      .haddr_i(haddr_i),
      .htrans_i(htrans_i),
      .hwrite_i(hwrite_i),
      .hsize_i(hsize_i),
      .hwdata_i(hwdata_i),
      .hready_i(hready_i),
      .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o),
      .stat_word_i(stat_word),
      .outs_word_i(outs_word),
      .capt_word_i(capt_word),
      .ctrl_o(ctrl_w)
   );

   //==========================================================
   // Checks
   //==========================================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   chk_status_shift: assert property (
      link_on && s_rise && s_ld_n && $stable(link_on) |=>
         s_chain_r == {$past(s_chain_r[SW-2:0]), $past(s_din)} || !link_on)
      else $error("status chain did not shift one place");

   chk_status_load: assert property (
      link_on && s_rise && !s_ld_n |=> s_chain_r == $past(stat_vec) || !link_on)
      else $error("status chain missed parallel load");

   chk_status_out: assert property (
      normal |-> status_chain_out_oe_o && status_chain_out_o == s_chain_r[SW-1])
      else $error("status output not driven from chain end");

   chk_chain_float: assert property (
      !pv ##1 !pv |-> !status_chain_out_oe_o && !control_chain_out_oe_o)
      else $error("chain output driven while power invalid");

   chk_ctrl_shift: assert property (
      link_on && c_rise ##1 link_on |->
         c_chain_r == {$past(c_chain_r[CW-2:0]), $past(c_din)})
      else $error("control chain did not shift");

   chk_latch_copy: assert property (
      pv && l_take && !l_clr |=> ((lat_r ^ $past(c_chain_r)) & ~rst_mask) == '0 || !pv)
      else $error("control latch did not copy chain");

   chk_reset_latch: assert property (
      pv && r_take && !r_clr && !l_clr |=>
         ((lat_r ^ $past(c_chain_r)) & rst_mask) == '0 || !pv)
      else $error("reset latch did not copy chain");

   chk_latch_clear: assert property (
      l_clr |=> (lat_r & ~rst_mask) == '0)
      else $error("control clear left bits set");

   chk_reset_clear: assert property (
      r_clr |=> (lat_r & rst_mask) == '0)
      else $error("reset clear left bits set");

   chk_output_hold: assert property (
      pv && !l_take && !r_take && !l_clr && !r_clr |=> lat_r == $past(lat_r))
      else $error("outputs changed without latch or clear");

   chk_switch_override: assert property (
      sw_5v[0] |-> main_power_enable_o[0] && !aux_power_enable_o[0])
      else $error("switch override not applied");

   chk_strap_sample: assert property (
      pv_rise && tst |=> test_mode_o && strap_select_o == $past({c_pin, s_pin}))
      else $error("strap or test mode not captured");
endmodule
`default_nettype wire

// [tb/hpsc_ctl_model.sv]
`default_nettype none
module hpsc_ctl_model (
   output logic sclk_o,
   output logic sdin_o,
   output logic sload_n_o,
   output logic cclk_o,
   output logic cdin_o,
   output wire logic clat_o,
   output wire logic rlat_o,
   output wire logic cclr_o,
   output wire logic rclr_o,
   input wire logic sout_i,
   input wire logic cout_i
);
   timeunit 1ns;
   timeprecision 1ps;
   //==========================================================
   // Link clocks idle low between frames
   logic [3:0] pl = 4'h0;
   assign {rclr_o, cclr_o, rlat_o, clat_o} = pl;
   initial begin
      sclk_o = 0;
      sdin_o = 0;
      sload_n_o = 1;
      cclk_o = 0;
      cdin_o = 0;
   end
   // Callers start a frame off the clock edge; 200 ns bits keep that phase
   task automatic stat_bit(input logic ld, input logic b, output logic o);
      o = sout_i;
      sload_n_o = !ld;
      sdin_o = b;
      #100 sclk_o = 1;
      #100 sclk_o = 0;
   endtask
   task automatic ctl_bit(input logic b, output logic o);
      o = cout_i;
      cdin_o = b;
      #100 cclk_o = 1;
      #100 cclk_o = 0;
   endtask
   // 0 control latch, 1 reset latch, 2 control clear, 3 reset clear
   task automatic pulse(input int k);
      #7 pl[k] = 1'b1;
      #100 pl[k] = 1'b0;
      #100;
   endtask
endmodule
`default_nettype wire

// [tb/hotplug_slot_serial_chain_tb_top.sv]
`default_nettype none
module hotplug_slot_serial_chain_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {string nm; int kd; logic [31:0] ex;} hpsc_note_t;
   logic clk_i = 0, nrst_i = 0, power_valid_in_i = 0, test_i = 0, aux_undervoltage_i = 0;
   logic [1:0] slot_switch_n_i = 0, slot_switch_5v_i = 0, main_power_fault_i = 0;
   logic [1:0] aux_overcurrent_i = 0, strap_pull = 2'b11, attention_button_i = 0;
   logic [1:0] presence_bit1_i = 0, presence_bit2_i = 0, speed66_capable_i = 0;
   logic [1:0] extended_mode_cap1_i = 0, extended_mode_cap2_i = 0;
   logic hsel_i = 0, hwrite_i = 0, lbit;
   logic [1:0] htrans_i = 0;
   logic [2:0] hsize_i = 0;
   logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, r = 32'h39ff_416a;
   wire logic hready_i, hresp_o, test_mode_o, status_shift_clock_i, status_chain_in_i;
   wire logic status_capture_strobe_n_i, control_shift_clock_i, control_chain_in_i;
   wire logic control_latch_clock_i, slot_reset_latch_clock_i, control_latch_clear_i;
   wire logic slot_reset_latch_clear_i, status_chain_out_o, status_chain_out_oe_o;
   wire logic control_chain_out_o, control_chain_out_oe_o;
   wire logic [1:0] main_power_enable_o, aux_power_enable_o, bus_connect_enable_o;
   wire logic [1:0] clock_connect_enable_o, slot_bus_reset_o, attention_indicator_o;
   wire logic [1:0] power_indicator_o, strap_select_o;
   // Chain pins float to the board strap level while undriven
   wire logic status_chain_out_i = status_chain_out_oe_o ? status_chain_out_o : strap_pull[0];
   wire logic control_chain_out_i = control_chain_out_oe_o ? control_chain_out_o : strap_pull[1];
   int errors = 0, total_checks = 0, cyc = 0;
   hpsc_note_t q[$];
   hpsc_note_t n;
   hpsc_top dut_u (.clk_i, .nrst_i, .status_shift_clock_i, .status_chain_in_i,
      .status_capture_strobe_n_i, .status_chain_out_i, .status_chain_out_o,
      .status_chain_out_oe_o, .control_shift_clock_i, .control_chain_in_i,
      .control_chain_out_i, .control_chain_out_o, .control_chain_out_oe_o,
      .control_latch_clock_i, .slot_reset_latch_clock_i, .control_latch_clear_i,
      .slot_reset_latch_clear_i, .power_valid_in_i, .test_i, .slot_switch_n_i,
      .slot_switch_5v_i, .attention_button_i, .presence_bit1_i, .presence_bit2_i,
      .speed66_capable_i, .extended_mode_cap1_i, .extended_mode_cap2_i,
      .main_power_fault_i, .aux_overcurrent_i, .aux_undervoltage_i, .main_power_enable_o,
      .aux_power_enable_o, .bus_connect_enable_o, .clock_connect_enable_o,
      .slot_bus_reset_o, .attention_indicator_o, .power_indicator_o, .test_mode_o,
      .strap_select_o, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
      .hready_i, .hrdata_o, .hreadyout_o(hready_i), .hresp_o);
   hpsc_ctl_model m_u (.sclk_o(status_shift_clock_i), .sdin_o(status_chain_in_i),
      .sload_n_o(status_capture_strobe_n_i), .cclk_o(control_shift_clock_i),
      .cdin_o(control_chain_in_i), .clat_o(control_latch_clock_i),
      .rlat_o(slot_reset_latch_clock_i), .cclr_o(control_latch_clear_i),
      .rclr_o(slot_reset_latch_clear_i), .sout_i(status_chain_out_i),
      .cout_i(control_chain_out_i));
   //==========================================================
   // Checking
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] seen(input int k);
      case (k)
         0: return hrdata_o;
         1: return {24'h0, bus_connect_enable_o, clock_connect_enable_o, slot_bus_reset_o,
            power_indicator_o};
         2: return {27'h0, test_mode_o, strap_select_o, status_chain_out_oe_o,
            control_chain_out_oe_o};
         3: return {31'h0, lbit};
         4: return {28'h0, main_power_enable_o, aux_power_enable_o};
         6: return {31'h0, hresp_o};
         default: return {28'h0, power_indicator_o, attention_indicator_o};
      endcase
   endfunction
   task automatic note(input string nm, input int kd, input logic [31:0] ex);
      q.push_back('{nm, kd, ex});
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
      total_checks++;
      if (sn !== ex) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, ex, sn);
      end
   endtask
   always @(posedge clk_i) begin
      while (q.size() > 0) begin
         n = q.pop_front();
         chk(n.nm, n.ex, seen(n.kd));
      end
   end
   task automatic stop_test;
      if (errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   //==========================================================
   // Stimulus
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'b10;
      haddr_i <= a;
      hwrite_i <= wr;
      hsize_i <= 3'b010;
      @(posedge clk_i);
      while (hready_i !== 1'b1) @(posedge clk_i);
      hsel_i <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= wd;
      @(posedge clk_i);
      while (hready_i !== 1'b1) @(posedge clk_i);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] ex);
      ahb(1'b0, a, 32'h0000_0000);
      note("hrdata", 0, ex);
      note("hresp", 6, 32'h0000_0000);
   endtask
   initial begin
      logic [11:0] v, w;
      logic [17:0] s;
      logic [18:0] d;
      logic o;
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      rd(32'h0000_0000, 32'h0000_0001);
      note("mode", 2, 32'h0000_0000);
      power_valid_in_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      note("mode", 2, 32'h0000_000F);
      rd(32'h0000_0004, 32'h0000_0033);
      ahb(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
      rd(32'h0000_0004, 32'h0000_0033);
      rd(32'h0000_0010, 32'h0000_0000);
      r = lfsr(r);
      v = r[11:0];
      #7;
      for (int i = 11; i >= 0; i--) m_u.ctl_bit(v[i], o);
      note("outs", 1, 32'h0000_0000);
      m_u.pulse(0);
      note("outs", 1, {24'h0, v[7], v[1], v[8], v[2], 2'b00, v[11], v[5]});
      m_u.pulse(1);
      note("outs", 1, {24'h0, v[7], v[1], v[8], v[2], v[9], v[3], v[11], v[5]});
      test_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      note("indicators", 5, {28'h0, v[6], v[0], 2'b00});
      test_i <= 1'b0;
      r = lfsr(r);
      w = r[11:0];
      #7;
      for (int i = 11; i >= 0; i--) begin
         m_u.ctl_bit(w[i], o);
         lbit = o;
         note("ctl_out", 3, {31'h0, v[i]});
      end
      note("outs", 1, {24'h0, v[7], v[1], v[8], v[2], v[9], v[3], v[11], v[5]});
      ahb(1'b1, 32'h0000_0000, 32'h0000_0002);
      rd(32'h0000_0000, 32'h0000_0002);
      m_u.pulse(0);
      note("outs", 1, {24'h0, v[7], v[1], v[8], v[2], v[9], v[3], v[11], v[5]});
      ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
      m_u.pulse(2);
      note("outs", 1, {28'h0, v[9], v[3], 2'b00});
      m_u.pulse(3);
      note("outs", 1, 32'h0000_0000);
      r = lfsr(r);
      slot_switch_n_i <= 2'b10;
      {attention_button_i, presence_bit1_i, presence_bit2_i, speed66_capable_i,
         extended_mode_cap1_i, extended_mode_cap2_i} <= r[11:0];
      repeat (4) @(posedge clk_i);
      for (int j = 0; j < 2; j++) begin
         s[9*j +: 9] = {2'b11, extended_mode_cap2_i[j], extended_mode_cap1_i[j],
            speed66_capable_i[j], presence_bit2_i[j], presence_bit1_i[j],
            attention_button_i[j], slot_switch_n_i[j]};
      end
      d = r[30:12];
      #7;
      m_u.stat_bit(1'b1, 1'b0, o);
      for (int i = 0; i < 19; i++) begin
         m_u.stat_bit(1'b0, d[i], o);
         lbit = o;
         if (i < 18) note("stat_out", 3, {31'h0, s[17-i]});
         else note("stat_out", 3, {31'h0, d[0]});
      end
      for (int k = 0; k < 3; k++) begin
         {slot_switch_n_i, slot_switch_5v_i} <= (k == 0) ? 4'h0 : (k == 1) ? 4'h1 : 4'h8;
         repeat (5) @(posedge clk_i);
         note("power", 4, (k == 0) ? 32'h3 : (k == 1) ? 32'h6 : 32'h1);
      end
      aux_undervoltage_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      aux_undervoltage_i <= 1'b0;
      rd(32'h0000_0004, 32'h0000_00F3);
      power_valid_in_i <= 1'b0;
      test_i <= 1'b1;
      strap_pull <= 2'b01;
      repeat (8) @(posedge clk_i);
      power_valid_in_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      note("mode", 2, 32'h0000_0014);
      repeat (3) @(posedge clk_i);
      stop_test();
   end
endmodule
`default_nettype wire
